// >>> src/ppseq_pkg.sv
/*
 * Shared constants, encodings and carrier structs for the bit programming sequencer.
 * Assumes a 100 MHz system clock and an external analog front end that turns the
 * enable pins into programming and sense currents and compares the sensed voltage.
 */
package ppseq_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Geometry of the memory being programmed, and counter widths.
   localparam int ADDR_W = 10;
   localparam int DATA_W = 4;
   localparam int BIT_W  = 2;
   localparam int PCNT_W = 8;
   localparam int TMR_W  = 11;
   localparam int TAIL_W = 3;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing, in nanoseconds as specified, and in clock cycles.
   localparam int CLK_NS     = 10;
   localparam int PULSE_NS   = 7500;
   localparam int CONFIRM_NS = 10000;
   localparam int QUIET_NS   = 10000;
   localparam int SETTLE_NS  = 700;
   localparam int TAIL_PULSES = 4;

   function automatic int cyc_up(input int ns);
      return (ns + CLK_NS - 1) / CLK_NS;
   endfunction

   localparam int PULSE_CYC   = PULSE_NS / CLK_NS;
   localparam int CONFIRM_CYC = cyc_up(CONFIRM_NS);
   localparam int QUIET_CYC   = cyc_up(QUIET_NS);
   localparam int SETTLE_CYC  = cyc_up(SETTLE_NS);

   // The pulse timer runs one short so the enable stands exactly the pulse width.
   localparam logic [TMR_W-1:0] PULSE_LOAD   = TMR_W'(PULSE_CYC - 1);
   localparam logic [TMR_W-1:0] CONFIRM_LOAD = TMR_W'(CONFIRM_CYC);
   localparam logic [TMR_W-1:0] QUIET_LOAD   = TMR_W'(QUIET_CYC);
   localparam logic [TMR_W-1:0] SETTLE_LOAD  = TMR_W'(SETTLE_CYC);
   localparam logic [TAIL_W-1:0] TAIL_LAST   = TAIL_W'(TAIL_PULSES);

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer states.
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_PRE   = 6'h02,
      ST_POST  = 6'h04,
      ST_SENSE = 6'h08,
      ST_PULSE = 6'h10,
      ST_STOP  = 6'h20
   } ppseq_state_e;

   ////////////////////////////////////////////////////////////////////////////////
   // Carriers.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [BIT_W-1:0]  bitsel;
      logic [PCNT_W-1:0] max_pulses;
   } ppseq_req_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [BIT_W-1:0]  bitsel;
      logic [PCNT_W-1:0] pulses;
   } ppseq_res_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              ce_disable;
      logic [DATA_W-1:0] prog_en;
      logic [DATA_W-1:0] sense_en;
   } ppseq_pins_s;

endpackage

// >>> src/ppseq_timer.sv
/*
 * Down-counting interval timer for the sequencer.
 * Assumes the loader holds load for one cycle; expired is high while the count is zero.
 */
`timescale 1ns/1ps
module ppseq_timer (
   // Clock and control.
   input  wire logic                       clock,
   input  wire logic                       reset,
   input  wire logic                       ce,
   // Load and status.
   input  wire logic                       load,
   input  wire logic [ppseq_pkg::TMR_W-1:0] load_val,
   output logic                            expired
);
   import ppseq_pkg::*;

   typedef struct packed {
      logic [TMR_W-1:0] cnt;
   } ppseq_tmr_s;

   ppseq_tmr_s r;
   ppseq_tmr_s next_r;

   always_comb begin
      next_r = r;
      if (load) begin
         next_r.cnt = load_val;
      end else if (r.cnt != '0) begin
         next_r.cnt = r.cnt - TMR_W'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         r <= '0;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign expired = (r.cnt == '0);

endmodule

// >>> src/ppseq.sv
/*
 * Programmer-side sequencer that writes one bit of a 1024 x 4 fuse memory at a time.
 * Assumes an analog front end: prog_en and sense_en switch the programming and sense
 * currents onto a data pin, and sense_pass is the comparator result, asynchronous.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// What this block does
// RL1: Sense the selected bit first, then pulse, then sense again.
// RL2: Keep the memory's chip enable disabled during the whole operation.
// RL3: Drive programming current into the selected data pin, also used for sensing.
// RL4: Each pulse lasts 7.5 us; sense after every pulse before the next.
// RL5: Repeat pulse then sense while the bit does not read as one.
// RL6: Pass means sensed voltage stays below the reference threshold.
// RL7: Confirm with two passing senses 10 us apart, no pulse between.
// RL8: After confirmation give four more pulses, end train, then remove sense current.
// RL9: Sense current off at least 10 us before and after any address change.
// RL10: Wait at least 0.7 us after a pulse ends before sampling.
// RL11: Drive all ten address lines before the pulse train starts.
// RL12: The memory holds 1024 four-bit words; bits only go from zero to one.
// RL13: Give up and report failure after a set maximum number of pulses.
// RL14: Signal completion of each bit, only then accept the next request.
module ppseq (
   // Clock, reset and enable.
   input  wire logic                 clock,
   input  wire logic                 reset,
   input  wire logic                 ce,
   // Request side.
   input  wire logic                 start,
   input  wire ppseq_pkg::ppseq_req_s req,
   output logic                      ready,
   output logic                      busy,
   // Result side.
   output logic                      done,
   output logic                      fail,
   output ppseq_pkg::ppseq_res_s     res,
   // Memory and front end.
   output ppseq_pkg::ppseq_pins_s    pins,
   input  wire logic                 sense_pass
);
   import ppseq_pkg::*;

   typedef struct packed {
      ppseq_state_e      st;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] new_addr;
      logic [BIT_W-1:0]  bitsel;
      logic [PCNT_W-1:0] max_pulses;
      logic [PCNT_W-1:0] pulses;
      logic [TAIL_W-1:0] tail_cnt;
      logic              tail;
      logic              first_pass;
      logic              failed;
      logic              ce_disable;
      logic [DATA_W-1:0] prog;
      logic [DATA_W-1:0] sense;
      logic              done;
      logic              fail;
      logic              sync1;
      logic              sync2;
   } ppseq_core_s;

   localparam ppseq_core_s CORE_RST = '{st: ST_IDLE, ce_disable: 1'b1, default: '0};

   function automatic logic [DATA_W-1:0] bit_onehot(input logic [BIT_W-1:0] b);
      return {{(DATA_W-1){1'b0}}, 1'b1} << b;
   endfunction

   ppseq_core_s      r;
   ppseq_core_s      next_r;
   logic             tmr_load;
   logic [TMR_W-1:0] tmr_val;
   logic             tmr_exp;
   logic             start_pulse;
   logic             sample;

   ////////////////////////////////////////////////////////////////////////////////
   // Interval timer.
   ppseq_timer u_timer (
      .clock    (clock),
      .reset    (reset),
      .ce       (ce),
      .load     (tmr_load),
      .load_val (tmr_val),
      .expired  (tmr_exp)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer.
   always_comb begin
      next_r      = r;
      next_r.done = 1'b0;
      next_r.fail = 1'b0;
      next_r.sync1 = sense_pass;
      next_r.sync2 = r.sync1;
      tmr_load    = 1'b0;
      tmr_val     = '0;
      start_pulse = 1'b0;
      sample      = 1'b0;
      case (r.st)
         ST_IDLE: begin
            if (start) begin                                             // [RL14]
               next_r.new_addr   = req.addr;
               next_r.bitsel     = req.bitsel;
               next_r.max_pulses = req.max_pulses;
               next_r.pulses     = '0;
               next_r.tail_cnt   = '0;
               next_r.tail       = 1'b0;
               next_r.first_pass = 1'b0;
               next_r.failed     = 1'b0;
               tmr_load          = 1'b1;
               tmr_val           = QUIET_LOAD;                           // [RL9]
               next_r.st         = ST_PRE;
            end
         end
         ST_PRE: begin
            if (tmr_exp) begin
               next_r.addr = r.new_addr;                                 // [RL11]
               tmr_load    = 1'b1;
               tmr_val     = QUIET_LOAD;                                 // [RL9]
               next_r.st   = ST_POST;
            end
         end
         ST_POST: begin
            if (tmr_exp) begin
               next_r.sense = bit_onehot(r.bitsel);                      // [RL1] [RL3]
               tmr_load     = 1'b1;
               tmr_val      = SETTLE_LOAD;
               next_r.st    = ST_SENSE;
            end
         end
         ST_SENSE: begin
            if (tmr_exp) begin
               sample = 1'b1;                                            // [RL10]
               // The synchronised comparator output is high when below threshold.
               if (r.tail) begin
                  if (r.tail_cnt == TAIL_LAST) begin                     // [RL8]
                     next_r.st = ST_STOP;
                  end else begin
                     start_pulse = 1'b1;
                  end
               end else if (r.sync2 && r.first_pass) begin               // [RL6] [RL7]
                  next_r.tail = 1'b1;
                  start_pulse = 1'b1;
               end else if (r.sync2) begin
                  next_r.first_pass = 1'b1;
                  tmr_load          = 1'b1;
                  tmr_val           = CONFIRM_LOAD;                      // [RL7]
               end else begin
                  next_r.first_pass = 1'b0;
                  if (r.pulses == r.max_pulses) begin                    // [RL13]
                     next_r.failed = 1'b1;
                     next_r.st     = ST_STOP;
                  end else begin
                     start_pulse = 1'b1;                                 // [RL5]
                  end
               end
            end
         end
         ST_PULSE: begin
            if (tmr_exp) begin
               next_r.prog = '0;
               tmr_load    = 1'b1;
               tmr_val     = SETTLE_LOAD;                                // [RL4] [RL10]
               next_r.st   = ST_SENSE;
            end
         end
         ST_STOP: begin
            next_r.sense = '0;                                           // [RL8]
            next_r.done  = ~r.failed;                                    // [RL14]
            next_r.fail  = r.failed;                                     // [RL13]
            next_r.st    = ST_IDLE;
         end
         default: begin
            next_r.st = ST_IDLE;
         end
      endcase
      if (start_pulse) begin
         next_r.prog = bit_onehot(r.bitsel);                             // [RL3]
         tmr_load    = 1'b1;
         tmr_val     = PULSE_LOAD;                                       // [RL4]
         next_r.st   = ST_PULSE;
         if (next_r.tail) begin
            next_r.tail_cnt = r.tail_cnt + TAIL_W'(1);
         end else begin
            next_r.pulses = r.pulses + PCNT_W'(1);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         r <= CORE_RST;
      end else if (ce) begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign ready           = (r.st == ST_IDLE);
   assign busy            = ~ready;
   assign done            = r.done;
   assign fail            = r.fail;
   assign res.addr        = r.addr;
   assign res.bitsel      = r.bitsel;
   assign res.pulses      = r.pulses;
   assign pins.addr       = r.addr;
   assign pins.ce_disable = r.ce_disable;                                // [RL2]
   assign pins.prog_en    = r.prog;
   assign pins.sense_en   = r.sense;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   localparam int A_PULSE   = PULSE_CYC;
   localparam int A_QUIET   = QUIET_CYC;
   localparam int A_SETTLE  = SETTLE_CYC;
   localparam int A_CONFIRM = CONFIRM_CYC;
   localparam logic [10:0] SAT = 11'h7FF;

   logic [10:0]       plen;
   logic [10:0]       quiet;
   logic [10:0]       since_addr;
   logic [10:0]       since_prog;
   logic [ADDR_W-1:0] addr_q;

   always_ff @(posedge clock) begin
      if (reset) begin
         plen       <= '0;
         quiet      <= '0;
         since_addr <= '0;
         since_prog <= '0;
         addr_q     <= '0;
      end else if (ce) begin
         addr_q     <= r.addr;
         plen       <= (|r.prog) ? plen + 11'h001 : 11'h000;
         quiet      <= (|r.sense) ? 11'h000 : ((quiet == SAT) ? SAT : quiet + 11'h001);
         since_prog <= (|r.prog) ? 11'h000 : ((since_prog == SAT) ? SAT : since_prog + 11'h001);
         if (r.addr != addr_q) begin
            since_addr <= 11'h001;
         end else if (since_addr != SAT) begin
            since_addr <= since_addr + 11'h001;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_ce_off;
      busy |-> pins.ce_disable;
   endproperty
   a_ce_off: assert property (p_ce_off) else $error("chip enable not held off"); // [RL2]

   property p_pulse_width;
      $fell(|pins.prog_en) |-> plen == 11'(A_PULSE);
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong"); // [RL4]

   property p_prog_pin;
      (|pins.prog_en) |-> (pins.prog_en == pins.sense_en) && $onehot(pins.prog_en);
   endproperty
   a_prog_pin: assert property (p_prog_pin) else $error("pulse not on sensed pin"); // [RL3]

   property p_quiet_before;
      $changed(pins.addr) |-> !(|pins.sense_en) && (quiet >= 11'(A_QUIET));
   endproperty
   a_quiet_before: assert property (p_quiet_before) else $error("sense on near addr"); // [RL9]

   property p_quiet_after;
      $rose(|pins.sense_en) |-> since_addr >= 11'(A_QUIET);
   endproperty
   a_quiet_after: assert property (p_quiet_after) else $error("sense on too soon"); // [RL9]

   property p_settle;
      sample && ce |-> since_prog >= 11'(A_SETTLE) && (|pins.sense_en);
   endproperty
   a_settle: assert property (p_settle) else $error("sampled too early"); // [RL10]

   property p_confirm;
      sample && ce && r.first_pass && r.sync2 && !r.tail |-> since_prog >= 11'(A_CONFIRM);
   endproperty
   a_confirm: assert property (p_confirm) else $error("confirm spacing wrong"); // [RL7]

   property p_tail;
      (r.st == ST_STOP) && !r.failed |-> r.tail && (r.tail_cnt == TAIL_LAST);
   endproperty
   a_tail: assert property (p_tail) else $error("tail pulse count wrong"); // [RL8]

   property p_limit;
      $rose(|pins.prog_en) && !r.tail |-> r.pulses <= r.max_pulses;
   endproperty
   a_limit: assert property (p_limit) else $error("pulse limit exceeded"); // [RL13]

   property p_end;
      (done || fail) |-> !(|pins.sense_en) && !(|pins.prog_en) && ready;
   endproperty
   a_end: assert property (p_end) else $error("bit end not clean"); // [RL8] [RL14]

endmodule

// >>> test/ppseq_fuse_model.sv
/*
 * Model of the 1024 x 4 fuse memory with its sense comparator, plus pulse statistics.
 * Assumes the sequencer's pins on the bench clock and a clear strobe from the bench.
 */
`timescale 1ns/1ps
module ppseq_fuse_model #(
   parameter int RECOVER = 50
) (
   // Clock and clear.
   input  wire logic                  clock,
   input  wire logic                  clr,
   // Pins and comparator.
   input  wire ppseq_pkg::ppseq_pins_s pins,
   input  wire logic [7:0]            need,
   output logic                       sense_pass,
   // Statistics.
   output logic [15:0]                pulses,
   output logic [15:0]                wmin,
   output logic [15:0]                wmax,
   output logic [15:0]                gmin,
   output logic [15:0]                gmax,
   output logic                       bad
);
   import ppseq_pkg::*;
   logic [DATA_W-1:0] mem [1024];
   logic [DATA_W-1:0] pe_q = 4'h0;
   logic [DATA_W-1:0] se_q = 4'h0;
   logic [ADDR_W-1:0] addr_q = 10'h000;
   logic [15:0]       w = 16'h0000;
   logic [15:0]       g = 16'hFFFF;
   logic [15:0]       q = 16'hFFFF;
   logic [15:0]       ac = 16'hFFFF;
   logic [15:0]       hits = 16'h0000;

   function automatic logic [15:0] sat(input logic [15:0] v);
      return (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction

   initial begin
      foreach (mem[i]) mem[i] = 4'h0;
   end

   // The pin voltage recovers some time after a pulse; before that no pass is seen.
   assign sense_pass = (|(pins.sense_en & mem[pins.addr])) && (pins.prog_en == 4'h0)
                       && (g >= 16'(RECOVER));

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      pe_q <= pins.prog_en;
      se_q <= pins.sense_en;
      addr_q <= pins.addr;
      w <= (pins.prog_en != 4'h0) ? w + 16'h0001 : 16'h0000;
      // An unknown pin before reset counts as off, so the gap counters never turn unknown.
      g <= (|pins.prog_en === 1'b1) ? 16'h0000 : sat(g);
      q <= (|pins.sense_en === 1'b1) ? 16'h0000 : sat(q);
      ac <= (pins.addr !== addr_q) ? 16'h0000 : sat(ac);
      if (pins.addr != addr_q) hits <= 16'h0000;
      if (pe_q != 4'h0 && pins.prog_en == 4'h0) begin
         hits <= hits + 16'h0001;
         // A bit only ever goes from zero to one.
         if (hits + 16'h0001 >= 16'(need)) mem[pins.addr] <= mem[pins.addr] | pe_q;
      end
      if (clr) begin
         pulses <= 16'h0000;
         wmin <= 16'hFFFF;
         wmax <= 16'h0000;
         gmin <= 16'hFFFF;
         gmax <= 16'h0000;
         bad <= 1'b0;
      end else begin
         if (pins.prog_en != 4'h0 && pe_q == 4'h0) begin
            pulses <= pulses + 16'h0001;
            if (pulses != 16'h0000) begin
               gmin <= (g < gmin) ? g : gmin;
               gmax <= (g > gmax) ? g : gmax;
            end
         end
         if (pe_q != 4'h0 && pins.prog_en == 4'h0) begin
            wmin <= (w < wmin) ? w : wmin;
            wmax <= (w > wmax) ? w : wmax;
         end
         if (pins.ce_disable !== 1'b1) bad <= 1'b1;
         if ($countones(pins.prog_en) > 1 || (pins.prog_en & ~pins.sense_en) != 4'h0) begin
            bad <= 1'b1;
         end
         if (pins.addr != addr_q && q < 16'h03E8) bad <= 1'b1;
         if (pins.sense_en != 4'h0 && se_q == 4'h0 && ac < 16'h03E7) bad <= 1'b1;
      end
   end
endmodule

// >>> test/test_ppseq.sv
/*
 * Self-checking bench for the bit programming sequencer against the fuse memory model.
 * Assumes a 100 MHz clock and the model's pulse statistics as the view of the pins.
 */
`timescale 1ns/1ps
module test_ppseq;
   import ppseq_pkg::*;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic        ce = 1'b1;
   logic        start = 1'b0;
   logic        clr = 1'b0;
   logic [7:0]  need = 8'h01;
   ppseq_req_s  req = '0;
   logic        ready, busy, done, fail, sense_pass, bad;
   ppseq_res_s  res;
   ppseq_pins_s pins;
   logic [15:0] pulses, wmin, wmax, gmin, gmax;
   int          miscompares = 0;
   int          samples_checked = 0;

   always #5 clock = ~clock;

   ppseq dut (.clock(clock), .reset(reset), .ce(ce), .start(start), .req(req),
              .ready(ready), .busy(busy), .done(done), .fail(fail), .res(res),
              .pins(pins), .sense_pass(sense_pass));
   ppseq_fuse_model model (.clock(clock), .clr(clr), .pins(pins), .need(need),
                           .sense_pass(sense_pass), .pulses(pulses), .wmin(wmin),
                           .wmax(wmax), .gmin(gmin), .gmax(gmax), .bad(bad));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic go(input logic [9:0] a, input logic [1:0] b, input logic [7:0] mp,
                     input logic [7:0] nd);
      @(posedge clock);
      req <= '{addr: a, bitsel: b, max_pulses: mp};
      need <= nd;
      clr <= 1'b1;
      start <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
      start <= 1'b0;
   endtask

   task automatic wait_end();
      int n;
      for (n = 0; n < 20000; n++) begin
         @(posedge clock);
         #1;
         if ((done | fail) === 1'b1) break;
      end
      if (n == 20000) begin
         miscompares++;
         test_done();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic s_new_bit();
      go(10'h3FF, 2'h3, 8'h0A, 8'h03);
      wait_end();
      chk(16'(done), 16'h0001);
      chk(16'(res.pulses), 16'h0003);
      chk(16'(res.bitsel), 16'h0003);
      chk(16'(pins.addr), 16'h03FF);
      chk(16'(pins.sense_en), 16'h0000);
      chk(pulses, 16'h0007);
      chk(wmin, 16'h02EE);
      chk(wmax, 16'h02EE);
      chk(16'(gmin >= 16'h0046), 16'h0001);
      chk(16'(gmax >= 16'h042F), 16'h0001);
      chk(16'(bad), 16'h0000);
   endtask

   task automatic s_again();
      go(10'h3FF, 2'h3, 8'h0A, 8'h03);
      wait_end();
      chk(16'(done), 16'h0001);
      chk(16'(res.pulses), 16'h0000);
      chk(pulses, 16'h0004);
      chk(16'(bad), 16'h0000);
   endtask

   task automatic s_limit();
      go(10'h155, 2'h1, 8'h02, 8'h05);
      wait_end();
      chk(16'(fail), 16'h0001);
      chk(16'(done), 16'h0000);
      chk(16'(res.pulses), 16'h0002);
      chk(pulses, 16'h0002);
      chk(16'(res.addr), 16'h0155);
      chk(16'(bad), 16'h0000);
   endtask

   task automatic s_zero();
      go(10'h0AA, 2'h0, 8'h00, 8'h01);
      wait_end();
      chk(16'(fail), 16'h0001);
      chk(pulses, 16'h0000);
      chk(16'(res.bitsel), 16'h0000);
      chk(16'(bad), 16'h0000);
   endtask

   task automatic s_busy();
      go(10'h2A5, 2'h2, 8'h08, 8'h01);
      repeat (20) @(posedge clock);
      ce <= 1'b0;
      repeat (40) @(posedge clock);
      #1;
      chk(16'(busy), 16'h0001);
      @(posedge clock);
      ce <= 1'b1;
      req <= '{addr: 10'h111, bitsel: 2'h1, max_pulses: 8'h03};
      start <= 1'b1;
      repeat (5) @(posedge clock);
      #1;
      chk(16'(ready), 16'h0000);
      @(posedge clock);
      start <= 1'b0;
      wait_end();
      chk(16'(done), 16'h0001);
      chk(16'(res.addr), 16'h02A5);
      chk(16'(res.bitsel), 16'h0002);
      chk(16'(res.pulses), 16'h0001);
      chk(16'(ready), 16'h0001);
   endtask

   initial begin
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      #1;
      chk(16'(ready), 16'h0001);
      chk(16'(pins.ce_disable), 16'h0001);
      chk(16'(pins.prog_en), 16'h0000);
      s_new_bit();
      s_again();
      s_limit();
      s_zero();
      s_busy();
      test_done();
   end
endmodule
